/* File: core/strobed_handshake_ports_cfg.svh */
// register offsets, field positions and reset values for the strobed ports
`ifndef STROBED_HANDSHAKE_PORTS_CFG_SVH
`define STROBED_HANDSHAKE_PORTS_CFG_SVH

`define OFS_FIRST_DATA 2'h0
`define OFS_SECOND_DATA 2'h1
`define OFS_HANDSHAKE 2'h2
`define OFS_MODE_CFG 2'h3

// mode word fields
`define CFG_FLAG_BIT 7
`define CFG_A_MODE_BIT 5
`define CFG_A_DIR_BIT 4
`define CFG_CU_DIR_BIT 3
`define CFG_B_MODE_BIT 2
`define CFG_B_DIR_BIT 1
`define CFG_CL_DIR_BIT 0

// bit op fields
`define BSR_SEL_HI 3
`define BSR_SEL_LO 1
`define BSR_VAL_BIT 0

// third port line positions
`define LINE_B_IRQ 0
`define LINE_B_FULL 1
`define LINE_B_ENA 2
`define LINE_A_IRQ 3
`define LINE_A_IN_ENA 4
`define LINE_A_IN_FULL 5
`define LINE_A_OUT_ENA 6
`define LINE_A_OUT_FULL 7

`define RST_BYTE 8'h00
`define RST_MODE_CFG 8'h9b

`endif

/* File: core/strobed_handshake_ports_pkg.sv */
// shared types for the strobed ports block
package strobed_handshake_ports_pkg;
    // one host register access
    typedef struct packed {
        logic [1:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } host_req_t;

    // decoded group direction
    typedef enum logic [1:0] {
        GRP_BASIC = 2'b00,
        GRP_IN = 2'b01,
        GRP_OUT = 2'b11
    } grp_mode_t;
endpackage

/* File: core/byte_skid_buffer.sv */
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/10ps
module byte_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest full and empty from the fill count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // pointers wrap at depth, not at a power of two
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: core/pin_sync.sv */
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds the second and nothing else; idle pins are high
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '1;
            sync_out <= '1;
        end else begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: core/strobed_handshake_ports.sv */
// strobed handshake transfer logic for two data ports and the third port
`timescale 1ns/10ps
`include "strobed_handshake_ports_cfg.svh"
module strobed_handshake_ports
    import strobed_handshake_ports_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire host_req_t host_req,
    output logic [7:0] host_rdata,
    input wire logic [7:0] first_port_in,
    output logic [7:0] first_port_out,
    output logic first_port_oe,
    input wire logic [7:0] second_port_in,
    output logic [7:0] second_port_out,
    output logic second_port_oe,
    input wire logic [7:0] third_port_in,
    output logic [7:0] third_port_out,
    output logic [7:0] third_port_oe,
    output logic first_irq_request,
    output logic second_irq_request
);
    ////////////////////////////////////////////////////////////////////////
    // line decode helper, used for both groups

    function automatic grp_mode_t grp_mode(input logic strobed,
                                           input logic dir_in);
        if (!strobed) begin
            return GRP_BASIC;
        end
        return dir_in ? GRP_IN : GRP_OUT;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration and host access decode

    logic [7:0] mode_q;
    logic [7:0] line_q;
    logic [7:0] rdata_d;
    wire wr_first = host_req.wr && host_req.addr == `OFS_FIRST_DATA;
    wire wr_second = host_req.wr && host_req.addr == `OFS_SECOND_DATA;
    wire wr_third = host_req.wr && host_req.addr == `OFS_HANDSHAKE;
    wire wr_cfg = host_req.wr && host_req.addr == `OFS_MODE_CFG;
    wire rd_first = host_req.rd && host_req.addr == `OFS_FIRST_DATA;
    wire rd_second = host_req.rd && host_req.addr == `OFS_SECOND_DATA;
    wire is_mode_wr = wr_cfg && host_req.wdata[`CFG_FLAG_BIT];
    wire is_bit_wr = wr_cfg && !host_req.wdata[`CFG_FLAG_BIT];
    wire [2:0] bit_sel = host_req.wdata[`BSR_SEL_HI:`BSR_SEL_LO];
    wire bit_val = host_req.wdata[`BSR_VAL_BIT];

    // two groups, each a data port and three handshake lines of the third port
    wire grp_mode_t a_mode = grp_mode(mode_q[`CFG_A_MODE_BIT],
                                      mode_q[`CFG_A_DIR_BIT]);
    wire grp_mode_t b_mode = grp_mode(mode_q[`CFG_B_MODE_BIT],
                                      mode_q[`CFG_B_DIR_BIT]);
    wire a_in = a_mode == GRP_IN;
    wire a_out = a_mode == GRP_OUT;
    wire b_in = b_mode == GRP_IN;
    wire b_out = b_mode == GRP_OUT;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the third port lines and both data ports

    logic [7:0] third_sync;
    logic [7:0] first_sync;
    logic [7:0] second_sync;

    pin_sync #(.WIDTH(8)) u_sync_third (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(third_port_in),
        .sync_out(third_sync)
    );
    pin_sync #(.WIDTH(16)) u_sync_data (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in({first_port_in, second_port_in}),
        .sync_out({first_sync, second_sync})
    );

    // strobe/ack on line 4/6 for first group, line 2 for second
    wire first_strobe_n = third_sync[`LINE_A_IN_ENA];
    wire first_acknowledge_n = third_sync[`LINE_A_OUT_ENA];
    wire second_strobe_n = third_sync[`LINE_B_ENA];
    wire second_acknowledge_n = third_sync[`LINE_B_ENA];
    logic a_hs_q;
    logic b_hs_q;
    wire a_hs_now = a_in ? first_strobe_n : first_acknowledge_n;
    wire b_hs_now = b_in ? second_strobe_n : second_acknowledge_n;
    wire a_fall = a_hs_q && !a_hs_now;
    wire b_fall = b_hs_q && !b_hs_now;
    wire a_rise = !a_hs_q && a_hs_now;
    wire b_rise = !b_hs_q && b_hs_now;

    ////////////////////////////////////////////////////////////////////////
    // input latches: strobe fall captures, data waits in a buffer

    logic first_input_full;
    logic second_input_full;
    logic [7:0] a_buf_data;
    logic [7:0] b_buf_data;
    logic a_buf_ready;
    logic b_buf_ready;

    // a strobe while full still queues one more byte; a strobe with both entries taken is lost
    byte_skid_buffer #(.WIDTH(8), .DEPTH(2)) u_buf_first (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .flush(is_mode_wr),
        .in_valid(a_in && a_fall),
        .in_ready(a_buf_ready),
        .in_data(first_sync),
        .out_valid(first_input_full),
        .out_ready(rd_first && a_in),
        .out_data(a_buf_data)
    );
    byte_skid_buffer #(.WIDTH(8), .DEPTH(2)) u_buf_second (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .flush(is_mode_wr),
        .in_valid(b_in && b_fall),
        .in_ready(b_buf_ready),
        .in_data(second_sync),
        .out_valid(second_input_full),
        .out_ready(rd_second && b_in),
        .out_data(b_buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // output latches and buffer-full flags

    logic [7:0] first_out_q;
    logic [7:0] second_out_q;
    logic first_output_full_n;
    logic second_output_full_n;
    logic first_irq_enable;
    logic second_irq_enable;

    // an ack edge in the write cycle loses to the write, so the
    // fresh byte is never reported as taken
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_output_full_n <= 1'b1;
            second_output_full_n <= 1'b1;
        end else begin
            if (is_mode_wr) begin
                first_output_full_n <= 1'b1;
            end else if (wr_first && a_out) begin
                first_output_full_n <= 1'b0;
            end else if (a_out && a_fall) begin
                first_output_full_n <= 1'b1;
            end
            if (is_mode_wr) begin
                second_output_full_n <= 1'b1;
            end else if (wr_second && b_out) begin
                second_output_full_n <= 1'b0;
            end else if (b_out && b_fall) begin
                second_output_full_n <= 1'b1;
            end
        end
    end

    // output data registers latch every host write to their own offset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_out_q <= `RST_BYTE;
            second_out_q <= `RST_BYTE;
            a_hs_q <= 1'b1;
            b_hs_q <= 1'b1;
        end else begin
            a_hs_q <= a_hs_now;
            b_hs_q <= b_hs_now;
            if (wr_first) begin
                first_out_q <= host_req.wdata;
            end
            if (wr_second) begin
                second_out_q <= host_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // third port: bit set/reset, enables, free lines

    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire [2:0] a_ena_line = a_in ? 3'(`LINE_A_IN_ENA)
                                 : 3'(`LINE_A_OUT_ENA);

    // enables live only in the bit op; mode words clear them
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= `RST_MODE_CFG;
            line_q <= `RST_BYTE;
            first_irq_enable <= 1'b0;
            second_irq_enable <= 1'b0;
        end else if (is_mode_wr) begin
            mode_q <= host_req.wdata;
            line_q <= `RST_BYTE;
            first_irq_enable <= 1'b0;
            second_irq_enable <= 1'b0;
        end else if (is_bit_wr) begin
            line_q <= bit_val ? (line_q | bit_mask)
                              : (line_q & ~bit_mask);
            if ((a_in && bit_sel == 3'(`LINE_A_IN_ENA))
                || (a_out && bit_sel == 3'(`LINE_A_OUT_ENA))) begin
                first_irq_enable <= bit_val;
            end
            if ((b_in || b_out) && bit_sel == 3'(`LINE_B_ENA)) begin
                second_irq_enable <= bit_val;
            end
        end else if (wr_third) begin
            line_q <= host_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // requests and status word

    wire a_req = first_irq_enable
        && (a_in ? first_input_full : (a_out && first_output_full_n));
    wire b_req = second_irq_enable
        && (b_in ? second_input_full : (b_out && second_output_full_n));

    // handshake lines owned by each group; rest stay free lines
    wire [7:0] a_own = a_in ? 8'h38 : (a_out ? 8'hc8 : 8'h00);
    wire [7:0] b_own = (b_in || b_out) ? 8'h07 : 8'h00;
    wire [7:0] a_stat = a_in
        ? {2'b00, first_input_full, first_irq_enable, a_req, 3'b000}
        : {first_output_full_n, first_irq_enable, 2'b00, a_req,
           3'b000};
    wire [7:0] b_stat = b_in
        ? {5'b00000, second_irq_enable, second_input_full, b_req}
        : {5'b00000, second_irq_enable, second_output_full_n,
           b_req};
    // strobes and acks are not read back, only flags are
    wire [7:0] free_lines = ~(a_own | b_own);
    wire [7:0] status_word = (a_stat & a_own) | (b_stat & b_own)
        | (third_sync & free_lines & ~third_port_oe);
    wire [7:0] free_out = line_q & free_lines;
    wire [7:0] hs_out = {first_output_full_n, 1'b0, first_input_full,
                         1'b0, a_req, 1'b0, b_in ? second_input_full
                         : second_output_full_n, b_req};

    // read mux, registered to meet the output rule
    always_comb begin
        rdata_d = `RST_BYTE;
        case (host_req.addr)
            `OFS_FIRST_DATA: rdata_d = a_in ? a_buf_data : first_out_q;
            `OFS_SECOND_DATA: rdata_d = b_in ? b_buf_data : second_out_q;
            `OFS_HANDSHAKE: rdata_d = status_word;
            default: rdata_d = `RST_BYTE;
        endcase
    end

    // drive pins; strobe/ack lines are inputs so never enabled
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata <= `RST_BYTE;
            first_port_out <= `RST_BYTE;
            second_port_out <= `RST_BYTE;
            first_port_oe <= 1'b0;
            second_port_oe <= 1'b0;
            third_port_out <= `RST_BYTE;
            third_port_oe <= `RST_BYTE;
            first_irq_request <= 1'b0;
            second_irq_request <= 1'b0;
        end else begin
            host_rdata <= host_req.rd ? rdata_d : `RST_BYTE;
            first_port_out <= first_out_q;
            second_port_out <= second_out_q;
            first_port_oe <= !mode_q[`CFG_A_DIR_BIT];
            second_port_oe <= !mode_q[`CFG_B_DIR_BIT];
            third_port_out <= (hs_out & (a_own | b_own)) | free_out;
            third_port_oe <= ((a_own | b_own) & 8'hab)
                | (free_lines & {{4{!mode_q[`CFG_CU_DIR_BIT]}},
                                 {4{!mode_q[`CFG_CL_DIR_BIT]}}});
            first_irq_request <= a_req;
            second_irq_request <= b_req;
        end
    end

    wire unused_ok = &{1'b0, a_buf_ready, b_buf_ready, a_rise, b_rise,
                       a_ena_line};
endmodule

/* File: bench/strobed_handshake_ports_sva.sv */
// concurrent checks on the strobed ports block
`timescale 1ns/10ps
module strobed_handshake_ports_sva
    import strobed_handshake_ports_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire host_req_t host_req,
    input wire logic [7:0] first_port_out,
    input wire logic first_port_oe,
    input wire logic [7:0] second_port_out,
    input wire logic second_port_oe,
    input wire logic [7:0] third_port_in,
    input wire logic [7:0] third_port_out,
    input wire logic [7:0] third_port_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // decoded host writes; line 6 driven means line 7 is a free line
    wire cfg_wr = host_req.wr && host_req.addr == 2'h3;
    wire a_wr = host_req.wr && host_req.addr == 2'h0;
    wire b_wr = host_req.wr && host_req.addr == 2'h1;
    wire a_out = third_port_oe[7] && !third_port_oe[6];
    wire free_76 = third_port_oe[7] && third_port_oe[6];
    wire bsr7 = cfg_wr && !host_req.wdata[7] && host_req.wdata[3:1] == 3'h7;
    ////////////////////////////////////////////////////////////////
    // handshake edges that start a flag change
    sequence strobe_fall_s;
        $fell(third_port_in[4]) && third_port_oe[5] && !third_port_oe[4]
            && !third_port_out[5];
    endsequence
    sequence ack_fall_s;
        $fell(third_port_in[6]) && a_out && !third_port_out[7];
    endsequence
    in_full_a: assert property (strobe_fall_s |-> ##[3:5] third_port_out[5])
        else $error("input full flag late");
    ack_empty_a: assert property (ack_fall_s |-> ##[3:5] third_port_out[7])
        else $error("output full flag not released by ack");
    full_write_a: assert property (a_wr && a_out |-> ##2 !third_port_out[7])
        else $error("output full flag not set by write");
    first_latch_a: assert property (
        a_wr |-> ##2 first_port_out == $past(host_req.wdata, 2))
        else $error("first output latch wrong");
    second_latch_a: assert property (
        b_wr |-> ##2 second_port_out == $past(host_req.wdata, 2))
        else $error("second output latch wrong");
    first_dir_a: assert property (cfg_wr && host_req.wdata[7] |->
        ##2 first_port_oe == !$past(host_req.wdata[4], 2))
        else $error("first port direction wrong");
    second_dir_a: assert property (cfg_wr && host_req.wdata[7] |->
        ##2 second_port_oe == !$past(host_req.wdata[1], 2))
        else $error("second port direction wrong");
    free_line_a: assert property (bsr7 && free_76 |->
        ##2 third_port_out[7] == $past(host_req.wdata[0], 2))
        else $error("bit op on free line wrong");
endmodule

bind strobed_handshake_ports strobed_handshake_ports_sva u_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req),
    .first_port_out(first_port_out), .first_port_oe(first_port_oe),
    .second_port_out(second_port_out), .second_port_oe(second_port_oe),
    .third_port_in(third_port_in), .third_port_out(third_port_out),
    .third_port_oe(third_port_oe)
);

/* File: bench/strobe_peripheral_model.sv */
// peripheral at the strobe side: strobes bytes in and acks bytes out
`timescale 1ns/10ps
module strobe_peripheral_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [1:0] sel,
    input wire logic [7:0] dat,
    input wire logic [3:0] dly,
    input wire logic [7:0] third_port_out,
    output logic [7:0] first_port_in,
    output logic [7:0] second_port_in,
    output logic [7:0] pin_drive,
    output logic busy
);
    initial begin
        first_port_in = 8'h00;
        second_port_in = 8'h00;
        pin_drive = 8'hff;
        busy = 1'b0;
    end
    // sel 0/1 strobe first/second, 2/3 ack first/second; data shows
    // its inverse after the strobe so a stale byte can never pass
    always @(posedge ref_clk) begin
        if (go) begin
            busy <= 1'b1;
            if (!sel[1]) begin
                if (sel[0])
                    second_port_in <= dat;
                else
                    first_port_in <= dat;
                @(posedge ref_clk);
                pin_drive[sel[0] ? 2 : 4] <= 1'b0;
                repeat (3) @(posedge ref_clk);
                pin_drive <= 8'hff;
                @(posedge ref_clk);
                if (sel[0])
                    second_port_in <= ~dat;
                else
                    first_port_in <= ~dat;
            end else begin
                // wait for the host byte, then ack after dly cycles
                repeat (200)
                    if (third_port_out[sel[0] ? 1 : 7])
                        @(posedge ref_clk);
                repeat (dly) @(posedge ref_clk);
                pin_drive[sel[0] ? 2 : 6] <= 1'b0;
                repeat (3) @(posedge ref_clk);
                pin_drive <= 8'hff;
            end
            busy <= 1'b0;
        end
    end
endmodule

/* File: bench/strobed_handshake_ports_bench.sv */
// self-checking bench for the strobed ports block
`timescale 1ns/10ps
module strobed_handshake_ports_bench;
    import strobed_handshake_ports_pkg::*;
    logic ref_clk, sys_rst, go, busy, a_oe, b_oe, a_irq, b_irq;
    host_req_t host_req;
    logic [1:0] sel;
    logic [3:0] dly;
    logic [7:0] dat, rd_val, rdata, a_in, a_out, b_in, b_out;
    logic [7:0] drv, c_in, c_out, c_oe;
    int bad_count, samples_checked;
    int cycles = 0;
    // wire level: design where it drives, peripheral elsewhere
    assign c_in = (c_oe & c_out) | (~c_oe & drv);
    strobed_handshake_ports u_strobed_handshake_ports (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req),
        .host_rdata(rdata), .first_port_in(a_in), .first_port_out(a_out),
        .first_port_oe(a_oe), .second_port_in(b_in),
        .second_port_out(b_out), .second_port_oe(b_oe),
        .third_port_in(c_in), .third_port_out(c_out), .third_port_oe(c_oe),
        .first_irq_request(a_irq), .second_irq_request(b_irq)
    );
    strobe_peripheral_model u_strobe_peripheral_model (
        .ref_clk(ref_clk), .go(go), .sel(sel), .dat(dat), .dly(dly),
        .third_port_out(c_out), .first_port_in(a_in),
        .second_port_in(b_in), .pin_drive(drv), .busy(busy)
    );
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one host access; read data is taken the cycle after rd
    task automatic bus(logic [1:0] a, logic w, logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{a, w, !w, d};
        @(posedge ref_clk);
        host_req <= '{a, 1'b0, 1'b0, d};
        #1 rd_val = rdata;
    endtask
    task automatic poll(logic [7:0] mask);
        for (int i = 0; i < 100; i++) begin
            bus(2'h2, 1'b0, 8'h00);
            if ((rd_val & mask) !== 8'h00)
                return;
        end
        check("poll", mask, 8'h00);
    endtask
    // strobes wait for the peripheral; acks run beside the host
    task automatic periph(logic [1:0] s, logic [7:0] d, logic [3:0] w);
        @(posedge ref_clk);
        go <= 1'b1;
        sel <= s;
        dat <= d;
        dly <= w;
        @(posedge ref_clk);
        go <= 1'b0;
        for (int i = 0; i < 40 && !s[1]; i++) begin
            @(posedge ref_clk);
            if (!busy)
                break;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic s_first_in;
        bus(2'h3, 1'b1, 8'hb0);
        bus(2'h3, 1'b1, 8'h09);
        bus(2'h3, 1'b1, 8'h0f);
        periph(2'h0, 8'h5a, 4'h0);
        check("free_line7", 8'h80, c_out & 8'h80);
        periph(2'h0, 8'ha5, 4'h0);
        periph(2'h0, 8'h3c, 4'h0);
        poll(8'h20);
        check("status_in_a", 8'h38, rd_val & 8'h38);
        check("first_irq", 8'h01, {7'h00, a_irq});
        bus(2'h3, 1'b1, 8'h08);
        bus(2'h2, 1'b0, 8'h00);
        check("status_no_ena", 8'h20, rd_val & 8'h38);
        bus(2'h0, 1'b0, 8'h00);
        check("first_byte1", 8'h5a, rd_val);
        poll(8'h20);
        bus(2'h0, 1'b0, 8'h00);
        check("first_byte2", 8'ha5, rd_val);
        bus(2'h2, 1'b0, 8'h00);
        check("first_dropped", 8'h00, rd_val & 8'h20);
    endtask
    task automatic s_second_in;
        bus(2'h3, 1'b1, 8'h86);
        bus(2'h3, 1'b1, 8'h05);
        periph(2'h1, 8'hc3, 4'h0);
        poll(8'h02);
        check("status_in_b", 8'h07, rd_val & 8'h07);
        check("second_irq", 8'h01, {7'h00, b_irq});
        bus(2'h1, 1'b0, 8'h00);
        check("second_byte", 8'hc3, rd_val);
        bus(2'h2, 1'b0, 8'h00);
        check("status_in_b2", 8'h04, rd_val & 8'h07);
    endtask
    // slow acknowledge on the first port
    task automatic s_first_out;
        bus(2'h3, 1'b1, 8'ha0);
        bus(2'h3, 1'b1, 8'h0d);
        bus(2'h2, 1'b1, 8'h30);
        bus(2'h2, 1'b0, 8'h00);
        check("status_out_a", 8'hc8, rd_val & 8'hc8);
        check("free_lines54", 8'h30, c_out & 8'h30);
        periph(2'h2, 8'h00, 4'hf);
        bus(2'h0, 1'b1, 8'h12);
        // the pin latch follows the register one clock later
        @(posedge ref_clk);
        #1;
        check("first_out", 8'h12, a_out);
        check("first_oe", 8'h01, {7'h00, a_oe});
        bus(2'h2, 1'b0, 8'h00);
        check("status_full_a", 8'h40, rd_val & 8'hc8);
        poll(8'h80);
        check("status_done_a", 8'hc8, rd_val & 8'hc8);
        check("first_irq_out", 8'h01, {7'h00, a_irq});
    endtask
    // prompt acknowledge on the second port
    task automatic s_second_out;
        bus(2'h3, 1'b1, 8'h84);
        bus(2'h3, 1'b1, 8'h05);
        bus(2'h2, 1'b0, 8'h00);
        check("status_out_b", 8'h07, rd_val & 8'h07);
        periph(2'h3, 8'h00, 4'h4);
        bus(2'h1, 1'b1, 8'h34);
        @(posedge ref_clk);
        #1;
        check("second_out", 8'h34, b_out);
        bus(2'h2, 1'b0, 8'h00);
        check("status_full_b", 8'h04, rd_val & 8'h07);
        poll(8'h02);
        check("second_irq_out", 8'h01, {7'h00, b_irq});
    endtask
    // cut a hang short well past the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run;
        end
    end
    initial begin
        sys_rst = 1'b1;
        host_req = '0;
        go = 1'b0;
        sel = 2'h0;
        dat = 8'h00;
        dly = 4'h0;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check("reset_oe", 8'h00, {6'h00, a_oe, b_oe});
        s_first_in;
        s_second_in;
        s_first_out;
        s_second_out;
        complete_run;
    end
endmodule
